// ===== verilog/nvsr_pkg.sv
// Package for the nonvolatile SRAM host controller: pin timing, sequences, types
package nvsr_pkg;
    // -----------------------------------------------------------------
    // Clock and pin timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int T_CYCLE_NS    = 25;       // Read or write cycle time
    localparam int T_PULSE_NS    = 20;       // Chip enable or write pulse width
    localparam int T_ACCESS_NS   = 25;       // Chip enable access time
    localparam int T_HIZ_NS      = 10;       // Chip disable to output inactive
    localparam int T_RECALL_US   = 20;       // Software recall duration
    localparam int T_RESTORE_US  = 550;      // Power-up recall duration
    localparam int T_STORE_MS    = 10;       // Store cycle duration

    // Least times round up, and each is at least one cycle
    localparam int CYC_PULSE   = (T_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_ACCESS  = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_CYCLE   = (T_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_HIZ     = (T_HIZ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_RECALL  = (T_RECALL_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_RESTORE = (T_RESTORE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_STORE   = int'((64'(T_STORE_MS) * 64'd1000000000 + 64'(CLK_PERIOD_PS) - 64'd1)
                                      / 64'(CLK_PERIOD_PS));

    // -----------------------------------------------------------------
    // Bus widths and software sequences
    // -----------------------------------------------------------------
    localparam int ADDR_W   = 13;
    localparam int DATA_W   = 8;
    localparam int SEQ_LEN  = 6;
    localparam int WAIT_W   = 32;

    localparam logic [12:0] SEQ_A0       = 13'h0000;
    localparam logic [12:0] SEQ_A1       = 13'h1555;
    localparam logic [12:0] SEQ_A2       = 13'h0aaa;
    localparam logic [12:0] SEQ_A3       = 13'h1fff;
    localparam logic [12:0] SEQ_A4       = 13'h10f0;
    localparam logic [12:0] SEQ_STORE_A5 = 13'h0f0f;
    localparam logic [12:0] SEQ_RECAL_A5 = 13'h0f0e;

    // -----------------------------------------------------------------
    // Types
    // -----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        NVSR_OP_READ   = 2'h0,
        NVSR_OP_WRITE  = 2'h1,
        NVSR_OP_STORE  = 2'h2,
        NVSR_OP_RECALL = 2'h3
    } nvsr_op_t;

    typedef struct packed
    {
        nvsr_op_t            op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } nvsr_req_t;

    typedef struct packed
    {
        logic                ce_n;
        logic                we_n;
        logic                oe_n;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   dq_out;
        logic                dq_oe;
    } nvsr_pins_t;
endpackage

// ===== verilog/nvsr_wait_timer.sv
// Loadable down-counter that reports when a wait has run out
`timescale 1ns/1ps
module nvsr_wait_timer
#(
    parameter int W = 32
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              done
);
    logic [W-1:0] remain;
    logic [W-1:0] next_remain;

    // Next count: reload or count down to zero
    always_comb
    begin
        next_remain = remain;
        if (load)
            next_remain = count;
        else if (remain != '0)
            next_remain = remain - W'(1);
    end

    // Register the count
    always_ff @(posedge clk)
    begin
        if (rst)
            remain <= '0;
        else
            remain <= next_remain;
    end

    // Done follows the count only, so a caller that loads on done forms no loop
    assign done = (remain == '0);
endmodule

// ===== verilog/nvsr_host.sv
// Host controller driving a byte-wide nonvolatile SRAM over its pins
`timescale 1ns/1ps
module nvsr_host
#(
    parameter int STORE_CYCLES   = nvsr_pkg::CYC_STORE,
    parameter int RESTORE_CYCLES = nvsr_pkg::CYC_RESTORE,
    parameter int RECALL_CYCLES  = nvsr_pkg::CYC_RECALL
)
(
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire nvsr_pkg::nvsr_req_t         req,
    output logic                             rsp_valid,
    output logic [nvsr_pkg::DATA_W-1:0]      rsp_rdata,
    input  wire logic                        power_ok,
    output logic                             busy,
    output logic                             ce_n,
    output logic                             we_n,
    output logic                             oe_n,
    output logic [nvsr_pkg::ADDR_W-1:0]      addr,
    output logic [nvsr_pkg::DATA_W-1:0]      dq_out,
    output logic                             dq_oe,
    input  wire logic [nvsr_pkg::DATA_W-1:0] dq_in
);
    import nvsr_pkg::*;

    // ---------------------------------------------------------------
    // Constants and state
    // ---------------------------------------------------------------
    localparam logic [WAIT_W-1:0] W_PULSE  = WAIT_W'(CYC_ACCESS + 3);
    localparam logic [WAIT_W-1:0] W_WPULSE = WAIT_W'(CYC_PULSE);
    localparam logic [WAIT_W-1:0] W_GAP    = WAIT_W'(CYC_HIZ);
    localparam logic [WAIT_W-1:0] W_STORE  = WAIT_W'(STORE_CYCLES);
    localparam logic [WAIT_W-1:0] W_REST   = WAIT_W'(RESTORE_CYCLES);
    localparam logic [WAIT_W-1:0] W_RECALL = WAIT_W'(RECALL_CYCLES);

    typedef enum logic [5:0]
    {
        ST_POWER = 6'b000001,
        ST_IDLE  = 6'b000010,
        ST_SETUP = 6'b000100,
        ST_PULSE = 6'b001000,
        ST_GAP   = 6'b010000,
        ST_NVOP  = 6'b100000
    } nvsr_state_t;

    nvsr_state_t            state;
    nvsr_state_t            next_state;
    nvsr_req_t              cur;
    nvsr_req_t              next_cur;
    logic [2:0]             step;
    logic [2:0]             next_step;
    nvsr_pins_t             pins;
    nvsr_pins_t             next_pins;
    logic                   next_rsp_valid;
    logic [DATA_W-1:0]      next_rsp_rdata;
    logic                   pwr_s1;
    logic                   pwr_s2;
    logic                   pwr_s3;
    logic                   pwr_good;
    logic                   next_pwr_good;
    logic                   t_load;
    logic [WAIT_W-1:0]      t_count;
    logic                   t_done;
    logic [DATA_W-1:0]      dq_s1;
    logic [DATA_W-1:0]      dq_s2;

    // Sequence address for each step of a store or recall
    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] s, input nvsr_op_t op);
        logic [ADDR_W-1:0] a;
        a = SEQ_A0;
        case (s)
            3'h0: a = SEQ_A0;
            3'h1: a = SEQ_A1;
            3'h2: a = SEQ_A2;
            3'h3: a = SEQ_A3;
            3'h4: a = SEQ_A4;
            default: a = (op == NVSR_OP_STORE) ? SEQ_STORE_A5 : SEQ_RECAL_A5;
        endcase
        return a;
    endfunction

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    // Power-good pin through three flops; accepted when last two agree
    always_comb
    begin
        next_pwr_good = pwr_good;
        if (pwr_s2 == pwr_s3)
            next_pwr_good = pwr_s3;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pwr_s1   <= 1'b0;
            pwr_s2   <= 1'b0;
            pwr_s3   <= 1'b0;
            pwr_good <= 1'b0;
            dq_s1    <= '0;
            dq_s2    <= '0;
        end
        else
        begin
            pwr_s1   <= power_ok;
            pwr_s2   <= pwr_s1;
            pwr_s3   <= pwr_s2;
            pwr_good <= next_pwr_good;
            dq_s1    <= dq_in;
            dq_s2    <= dq_s1;
        end
    end

    nvsr_wait_timer #(.W(WAIT_W)) u_timer
    (
        .clk   (clk),
        .rst   (rst),
        .load  (t_load),
        .count (t_count),
        .done  (t_done)
    );

    // ---------------------------------------------------------------
    // Access sequencer
    // ---------------------------------------------------------------
    // Next state, pins and response
    always_comb
    begin
        next_state     = state;
        next_cur       = cur;
        next_step      = step;
        next_pins      = pins;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        t_load         = 1'b0;
        t_count        = '0;
        unique case (state)
            ST_POWER:
            begin
                // Wait out the power-up recall after supply comes good
                if (!pwr_good)
                begin
                    t_load  = 1'b1;
                    t_count = W_REST;
                end
                else if (t_done)
                    next_state = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (!pwr_good)
                begin
                    // Power loss starts a store; hold off past it
                    next_state = ST_POWER;
                end
                else if (req_valid)
                begin
                    next_cur     = req;
                    next_step    = 3'h0;
                    next_pins.addr = (req.op == NVSR_OP_READ || req.op == NVSR_OP_WRITE)
                                     ? req.addr : seq_addr(3'h0, req.op);
                    next_state   = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                // Address stable; assert chip enable; strobes set in the same cycle
                next_pins.ce_n = 1'b0;
                if (cur.op == NVSR_OP_WRITE)
                begin
                    next_pins.we_n   = 1'b0;
                    next_pins.oe_n   = 1'b1;
                    next_pins.dq_out = cur.wdata;
                    next_pins.dq_oe  = 1'b1;
                    t_count          = W_WPULSE;
                end
                else
                begin
                    next_pins.we_n  = 1'b1;
                    next_pins.oe_n  = 1'b0;
                    next_pins.dq_oe = 1'b0;
                    t_count         = W_PULSE;
                end
                t_load     = 1'b1;
                next_state = ST_PULSE;
            end
            ST_PULSE:
            begin
                if (!pwr_good)
                begin
                    // Device is deselected; abort and report nothing
                    next_pins.ce_n  = 1'b1;
                    next_pins.we_n  = 1'b1;
                    next_pins.oe_n  = 1'b1;
                    next_pins.dq_oe = 1'b0;
                    next_state      = ST_POWER;
                end
                else if (t_done)
                begin
                    next_pins.ce_n  = 1'b1;
                    next_pins.we_n  = 1'b1;
                    next_pins.oe_n  = 1'b1;
                    next_pins.dq_oe = 1'b0;
                    if (cur.op == NVSR_OP_READ)
                        next_rsp_rdata = dq_s2;
                    t_load     = 1'b1;
                    t_count    = W_GAP;
                    next_state = ST_GAP;
                end
            end
            ST_GAP:
            begin
                if (t_done)
                begin
                    if ((cur.op == NVSR_OP_STORE || cur.op == NVSR_OP_RECALL)
                        && step != 3'(SEQ_LEN - 1))
                    begin
                        next_step      = step + 3'h1;
                        next_pins.addr = seq_addr(step + 3'h1, cur.op);
                        next_state     = ST_SETUP;
                    end
                    else if (cur.op == NVSR_OP_STORE || cur.op == NVSR_OP_RECALL)
                    begin
                        t_load     = 1'b1;
                        t_count    = (cur.op == NVSR_OP_STORE) ? W_STORE : W_RECALL;
                        next_state = ST_NVOP;
                    end
                    else
                    begin
                        next_rsp_valid = 1'b1;
                        next_state     = ST_IDLE;
                    end
                end
            end
            ST_NVOP:
            begin
                // Hold all access until the store or recall finishes
                if (t_done)
                begin
                    next_rsp_valid = 1'b1;
                    next_state     = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state     <= ST_POWER;
            cur       <= '0;
            step      <= 3'h0;
            pins      <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end
        else
        begin
            state     <= next_state;
            cur       <= next_cur;
            step      <= next_step;
            pins      <= next_pins;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign req_ready = (state == ST_IDLE) && pwr_good;
    assign busy      = (state != ST_IDLE);
    assign ce_n      = pins.ce_n;
    assign we_n      = pins.we_n;
    assign oe_n      = pins.oe_n;
    assign addr      = pins.addr;
    assign dq_out    = pins.dq_out;
    assign dq_oe     = pins.dq_oe;
endmodule

// ===== verification/nvsr_host_checker.sv
// Pin and handshake assertions for the host controller
`timescale 1ns/1ps
module nvsr_host_checker
#(
    parameter int STORE_CYCLES   = 20,
    parameter int RESTORE_CYCLES = 20,
    parameter int RECALL_CYCLES  = 10
)
(
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        req_valid,
    input wire logic                        req_ready,
    input wire nvsr_pkg::nvsr_req_t         req,
    input wire logic                        rsp_valid,
    input wire logic                        power_ok,
    input wire logic                        ce_n,
    input wire logic                        we_n,
    input wire logic                        oe_n,
    input wire logic [nvsr_pkg::ADDR_W-1:0] addr,
    input wire logic                        dq_oe
);
    import nvsr_pkg::*;
    logic take, nv_on, next_nv_on, nv_st, next_nv_st;
    int   nv_cnt, next_nv_cnt, up_cnt, next_up_cnt;
    // Track a running store or recall and the time with good supply
    always_comb
    begin
        take        = req_valid && req_ready;
        next_nv_on  = rsp_valid ? 1'b0 : nv_on;
        next_nv_st  = nv_st;
        next_nv_cnt = nv_cnt + 1;
        next_up_cnt = power_ok ? up_cnt + 1 : 0;
        if (take)
        begin
            next_nv_on  = req.op inside {NVSR_OP_STORE, NVSR_OP_RECALL};
            next_nv_st  = req.op == NVSR_OP_STORE;
            next_nv_cnt = 0;
        end
    end
    always_ff @(posedge clk)
    begin
        nv_on  <= rst ? 1'b0 : next_nv_on;
        nv_st  <= next_nv_st;
        nv_cnt <= next_nv_cnt;
        up_cnt <= rst ? 0 : next_up_cnt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Opens at the first address, no write strobe, both nonvolatile waits
    seq_no_write_a: assert property (nv_on |-> we_n && !dq_oe)
        else $error("write strobe inside a store or recall");
    seq_start_a: assert property (take && next_nv_on |-> ##[1:4] ($fell(ce_n) && addr == SEQ_A0))
        else $error("sequence does not open at the first address");
    nv_wait_a: assert property (rsp_valid && nv_on |->
        nv_cnt >= (nv_st ? STORE_CYCLES : RECALL_CYCLES) + 6 * (CYC_ACCESS + 3 + CYC_HIZ))
        else $error("nonvolatile operation answered too early");
    // Strobe conventions
    read_strobe_a: assert property (!oe_n |-> we_n && !dq_oe)
        else $error("output enable with write strobe or drive");
    write_drive_a: assert property (!ce_n && !we_n |-> dq_oe && oe_n)
        else $error("write cycle without data drive");
    addr_hold_a: assert property (!ce_n && !$past(ce_n) |-> $stable(addr))
        else $error("address moved while enabled");
    // Supply handling
    power_block_a: assert property ($fell(power_ok) |-> ##[0:6] (ce_n && !req_ready))
        else $error("access not blocked after supply loss");
    restore_wait_a: assert property ($rose(req_ready) |-> up_cnt >= RESTORE_CYCLES)
        else $error("ready before power-up recall time");
    cover property (take && req.op == NVSR_OP_STORE);
    cover property (take && req.op == NVSR_OP_RECALL);
    cover property ($fell(power_ok) && !ce_n);
endmodule

bind nvsr_host nvsr_host_checker #(.STORE_CYCLES(STORE_CYCLES),
    .RESTORE_CYCLES(RESTORE_CYCLES), .RECALL_CYCLES(RECALL_CYCLES)) chk_u
    (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
     .rsp_valid(rsp_valid), .power_ok(power_ok), .ce_n(ce_n), .we_n(we_n),
     .oe_n(oe_n), .addr(addr), .dq_oe(dq_oe));

// ===== verification/nvsr_dev_model.sv
// Behavioural model of the nonvolatile SRAM at its pins
`timescale 1ns/1ps
module nvsr_dev_model
(
    input  wire logic        clk,
    input  wire logic        power_ok,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic [12:0] addr,
    input  wire logic [7:0]  dq,
    output logic [7:0]       dev_q,
    output logic             dev_en,
    output int               n_st = 0,
    output int               n_rc = 0
);
    import nvsr_pkg::*;
    localparam logic [12:0] SEQ [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    logic [7:0]  ram [8192];
    logic [7:0]  nv  [8192];
    logic [12:0] a;
    logic [7:0]  wd;
    logic        hiz, wr;
    int          idx = 0;
    // Copies are instant, so both nonvolatile times are met at once
    task automatic nv_save;
        nv = ram;
        n_st++;
    endtask
    task automatic nv_load;
        ram = nv;
        n_rc++;
    endtask
    // Enable fall latches the address and steps the unlock sequence
    always @(negedge ce_n)
    begin
        // Strobes launched with enable settle before they are read
        #0;
        a   = addr;
        wr  = !we_n;
        hiz = !we_n;
        if (!we_n || !power_ok)
            idx = 0;
        else if (idx == 5 && (addr == SEQ_STORE_A5 || addr == SEQ_RECAL_A5))
        begin
            hiz = 1'b1;
            idx = 0;
            if (addr == SEQ_STORE_A5)
                nv_save();
            else
                nv_load();
        end
        else
            idx = (idx < 5 && addr == SEQ[idx]) ? idx + 1 : int'(addr == SEQ_A0);
    end
    // Write data is sampled while both strobes are low
    always @(posedge clk)
        if (!ce_n && !we_n)
            wd <= dq;
    always @(posedge ce_n)
        if (wr && power_ok)
            ram[a] = wd;
    // Supply loss stores and clears the array, return recalls it
    always @(negedge power_ok)
    begin
        nv_save();
        foreach (ram[i])
            ram[i] = 8'h00;
    end
    always @(posedge power_ok)
        nv_load();
    assign dev_en = !ce_n && !oe_n && we_n && !hiz && power_ok;
    assign dev_q  = ram[a];
endmodule

// ===== verification/nvsr_host_tb.sv
// Self-checking bench for the nonvolatile SRAM host controller
`timescale 1ns/1ps
module nvsr_host_tb;
    import nvsr_pkg::*;
    localparam int          ST = 20;
    localparam int          RS = 20;
    localparam int          RC = 10;
    localparam int          SEQ_MIN = 6 * (CYC_ACCESS + 3 + CYC_HIZ);
    localparam logic [12:0] TA [3] = '{13'h0000, 13'h1fff, 13'h0f0e};
    localparam logic [7:0]  TD [3] = '{8'h00, 8'hff, 8'h5a};
    logic       clk, rst, req_valid, power_ok, req_ready, rsp_valid, busy;
    logic       ce_n, we_n, oe_n, dq_oe, dev_en;
    nvsr_req_t  req;
    logic [12:0] addr;
    logic [7:0] rsp_rdata, dq_out, dq_bus, last_dq, dev_q, rd;
    int         n_st, n_rc, bad_count, n_compared, cyc, lat;
    nvsr_host #(.STORE_CYCLES(ST), .RESTORE_CYCLES(RS), .RECALL_CYCLES(RC)) dut_u
        (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
         .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .power_ok(power_ok), .busy(busy),
         .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_out(dq_out),
         .dq_oe(dq_oe), .dq_in(dq_bus));
    nvsr_dev_model dev_u
        (.clk(clk), .power_ok(power_ok), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
         .addr(addr), .dq(dq_bus), .dev_q(dev_q), .dev_en(dev_en), .n_st(n_st), .n_rc(n_rc));
    // Shared data line; a changing pattern when nobody drives it
    assign dq_bus = dq_oe ? dq_out : (dev_en ? dev_q : ~last_dq);
    always @(posedge clk)
        last_dq <= dq_bus;
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk_data(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_flag(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask
    // Requests are offered at a falling edge and held until taken
    task automatic op_start(input nvsr_op_t o, input logic [12:0] a, input logic [7:0] d);
        int n;
        req       = '{o, a, d};
        req_valid = 1'b1;
        for (n = 0; n < 300 && req_ready !== 1'b1; n++)
            @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
    endtask
    task automatic op(input nvsr_op_t o, input logic [12:0] a, input logic [7:0] d);
        op_start(o, a, d);
        for (lat = 0; lat < 900 && rsp_valid !== 1'b1; lat++)
            @(negedge clk);
        rd = rsp_rdata;
        chk_flag("rsp_valid", 1'b1, rsp_valid);
    endtask
    task automatic wait_ready(input string nm);
        int n;
        for (n = 0; n < 300 && req_ready !== 1'b1; n++)
            @(negedge clk);
        chk_flag(nm, 1'b1, n >= RS && n < 300);
        chk_flag({nm, " busy"}, 1'b0, busy);
    endtask
    task automatic t_rw;
        for (int i = 0; i < 3; i++)
            op(NVSR_OP_WRITE, TA[i], TD[i]);
        for (int i = 0; i < 3; i++)
        begin
            op(NVSR_OP_READ, TA[i], 8'h00);
            chk_data("read data", TD[i], rd);
        end
    endtask
    task automatic t_nv;
        int s0;
        int r0;
        s0 = n_st;
        r0 = n_rc;
        op(NVSR_OP_WRITE, 13'h0100, 8'h3c);
        op(NVSR_OP_STORE, 13'h0000, 8'h00);
        chk_flag("store wait", 1'b1, lat >= ST + SEQ_MIN);
        op(NVSR_OP_WRITE, 13'h0100, 8'hc3);
        op(NVSR_OP_RECALL, 13'h0000, 8'h00);
        chk_flag("recall wait", 1'b1, lat >= RC + SEQ_MIN);
        chk_data("stores", 8'h01, 8'(n_st - s0));
        chk_data("recalls", 8'h01, 8'(n_rc - r0));
        op(NVSR_OP_READ, 13'h0100, 8'h00);
        chk_data("recalled", 8'h3c, rd);
    endtask
    task automatic t_power;
        int   s0;
        logic seen;
        s0   = n_st;
        seen = 1'b0;
        op(NVSR_OP_WRITE, 13'h0200, 8'ha5);
        op_start(NVSR_OP_READ, 13'h0200, 8'h00);
        repeat (3) @(negedge clk);
        power_ok = 1'b0;
        repeat (40)
        begin
            @(negedge clk);
            seen = seen | rsp_valid;
        end
        chk_flag("aborted rsp", 1'b0, seen);
        chk_flag("ce_n off", 1'b1, ce_n);
        chk_flag("ready off", 1'b0, req_ready);
        chk_flag("busy on", 1'b1, busy);
        chk_data("power store", 8'h01, 8'(n_st - s0));
        power_ok = 1'b1;
        wait_ready("power return");
        op(NVSR_OP_READ, 13'h0200, 8'h00);
        chk_data("restored", 8'ha5, rd);
    endtask
    initial
    begin
        rst        = 1'b1;
        req_valid  = 1'b0;
        req        = '0;
        power_ok   = 1'b1;
        last_dq    = 8'h00;
        bad_count  = 0;
        n_compared = 0;
        cyc        = 0;
        repeat (4) @(negedge clk);
        chk_flag("reset ce_n", 1'b1, ce_n);
        chk_flag("reset ready", 1'b0, req_ready);
        chk_flag("reset busy", 1'b1, busy);
        rst = 1'b0;
        wait_ready("boot");
        t_rw();
        t_nv();
        t_power();
        print_verdict();
    end
endmodule
